// ===== design/spi_master_pkg.sv
package spi_master_pkg;

  localparam logic [7:0] OFS_CLOCK_DIVIDER     = 8'hD2;
  localparam logic [7:0] OFS_SERIAL_STATUS     = 8'hD3;
  localparam logic [7:0] OFS_TRANSMIT_HOLDING  = 8'hD4;
  localparam logic [7:0] OFS_RECEIVE_HOLDING   = 8'hD5;
  localparam logic [7:0] OFS_CONTROL_PRIMARY   = 8'hD6;
  localparam logic [7:0] OFS_INTERRUPT_ENABLES = 8'hD7;

  localparam logic [7:0] RST_CLOCK_DIVIDER     = 8'h04;
  localparam logic [7:0] RST_SERIAL_STATUS     = 8'h02;
  localparam logic [7:0] RST_HOLDING           = 8'h00;
  localparam logic [7:0] RST_CONTROL           = 8'h00;

  localparam logic [7:0] MASK_CONTROL_PRIMARY   = 8'h7E;
  localparam logic [7:0] MASK_INTERRUPT_ENABLES = 8'h0F;
  localparam logic [7:0] MASK_CLOCK_DIVIDER     = 8'hFC;

  localparam int BIT_TX_ON          = 6;
  localparam int BIT_RX_ON          = 5;
  localparam int BIT_UNIT_ON        = 4;
  localparam int BIT_SELECT_ON      = 3;
  localparam int BIT_LSB_FIRST      = 2;
  localparam int BIT_CLOCK_POLARITY = 1;

  localparam int BIT_TX_END_IRQ     = 3;
  localparam int BIT_OVERRUN_IRQ    = 2;
  localparam int BIT_TX_EMPTY_IRQ   = 1;
  localparam int BIT_RX_FULL_IRQ    = 0;

  localparam int FRAME_BITS         = 8;
  localparam int FIFO_DEPTH         = 8;

  typedef struct packed {
    logic       tx_on;
    logic       rx_on;
    logic       unit_on;
    logic       select_on;
    logic       lsb_first_sel;
    logic       clock_polarity_sel;
  } control_t;

  typedef struct packed {
    logic       busy;
    logic       tx_end_flag;
    logic       overrun_flag;
    logic       tx_empty_flag;
    logic       rx_full_flag;
  } status_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b11
  } shift_state_t;

endpackage

// ===== design/sync_fifo.sv
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic             out_valid_reg;

  wire mem_empty = (count_reg == '0);
  wire push      = in_valid && in_ready;
  wire refill    = !mem_empty && (!out_valid_reg || out_ready);
  wire pop_out   = out_valid_reg && out_ready;

  // the output register counts as one of the DEPTH words, so the whole buffer holds DEPTH
  wire [AW:0] held = count_reg + (AW+1)'(out_valid_reg);

  assign in_ready  = (held != (AW+1)'(DEPTH));
  assign out_data  = out_data_reg;
  assign out_valid = out_valid_reg;

  // read data leave through a register stage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_data_reg  <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (refill) begin
        rd_ptr_reg   <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
        out_data_reg <= mem[rd_ptr_reg];
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(refill);
      if (refill) begin
        out_valid_reg <= 1'b1;
      end else if (pop_out) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule

// ===== design/spi_master_controller.sv
`timescale 1ns/1ps
// What this block does
// RL1: master only, frames of exactly eight bits
// RL2: first data bit appears with the first generated clock edge
// RL3: send and receive at once over separate data lines
// RL4: eight-bit transmit and receive paths, holding register apart from shifter
// RL5: transmit byte is serialised; incoming bits assembled into receive byte
// RL6: data out, data in, clock out, optional select; grounded select works
// RL7: control bit 6 enables the transmitter
// RL8: control bit 5 enables the receiver
// RL9: control bit 4 is the overall unit enable
// RL10: control bit 3 lets the block drive the select output
// RL11: control bit 2 picks msb first (0) or lsb first (1)
// RL12: control bit 1 sets clock idle level and sampling edge
// RL13: enable bit 3 gates the transmission-end interrupt
// RL14: enable bit 2 gates the receive-overrun interrupt
// RL15: enable bit 1 gates the transmit-holding-empty interrupt
// RL16: enable bit 0 gates the receive-holding-full interrupt
// RL17: transmit holding is write only at its address
// RL18: receive holding is read only, first byte finished since its last read; bytes finished while it is full are dropped
// RL19: serial clock rate derived from system clock by divider register
// RL20: divisor is the sum of set divider bits, 4 to 252
// RL21: transmitter off stops both directions, clock held idle; a frame already under way still runs to its eighth bit first
// RL22: select driven low before transfer, raised after last bit
// RL23: eighth bit sent with nothing waiting sets end flag and interrupt
// RL24: reserved control bits read zero and ignore writes
module spi_master_controller
  import spi_master_pkg::*;
#(
  parameter int FIFO_WIDTH = FRAME_BITS,
  parameter int FIFO_DEP   = FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            irq,
  output logic            serial_data_out,
  input  wire logic       serial_data_in,
  output logic            serial_clock_out,
  output logic            slave_select_out,
  output logic            slave_select_oe_n,
  output logic            tx_fifo_ready
);

  logic [7:0]   divider_reg;
  logic [7:0]   ctrl_bits_reg;
  logic [7:0]   irq_en_reg;
  logic [7:0]   rx_hold_reg;
  logic         rx_full_reg;
  logic         overrun_reg;
  logic         tx_end_reg;
  logic [7:0]   tx_shift_reg;
  logic [7:0]   rx_shift_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   div_cnt_reg;
  logic         sclk_reg;
  logic         sdo_reg;
  logic         sel_reg;
  logic [7:0]   rdata_reg;
  logic         sdi_meta_reg;
  logic         sdi_sync_reg;
  logic         irq_reg;
  shift_state_t state_reg;
  shift_state_t state_next;

  control_t ctrl;
  status_t  status;

  assign ctrl.tx_on              = ctrl_bits_reg[BIT_TX_ON];
  assign ctrl.rx_on              = ctrl_bits_reg[BIT_RX_ON];
  assign ctrl.unit_on            = ctrl_bits_reg[BIT_UNIT_ON];
  assign ctrl.select_on          = ctrl_bits_reg[BIT_SELECT_ON];
  assign ctrl.lsb_first_sel      = ctrl_bits_reg[BIT_LSB_FIRST];
  assign ctrl.clock_polarity_sel = ctrl_bits_reg[BIT_CLOCK_POLARITY];

  // register decode
  wire wr_divider = reg_wr && (reg_addr == OFS_CLOCK_DIVIDER);
  wire wr_tx_hold = reg_wr && (reg_addr == OFS_TRANSMIT_HOLDING);     // see RL17
  wire wr_control = reg_wr && (reg_addr == OFS_CONTROL_PRIMARY);
  wire wr_irq_en  = reg_wr && (reg_addr == OFS_INTERRUPT_ENABLES);
  wire rd_status  = reg_rd && (reg_addr == OFS_SERIAL_STATUS);
  wire rd_rx_hold = reg_rd && (reg_addr == OFS_RECEIVE_HOLDING);

  // transmit holding path: writes enter an eight-word fifo in front of the shifter
  logic [7:0] fifo_out;
  logic       fifo_valid;
  logic       fifo_take;

  sync_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEP)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (reg_wdata),
    .in_valid  (wr_tx_hold),
    .in_ready  (tx_fifo_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // divisor is the sum of the set divider bits; bits 1:0 unused, so a multiple of four
  wire [7:0] divisor   = divider_reg & MASK_CLOCK_DIVIDER;               // see RL20
  wire [7:0] half_div  = {1'b0, divisor[7:1]};
  wire [7:0] half_last = (half_div == 8'h00) ? 8'h00 : half_div - 8'h01;
  wire       half_tick = (div_cnt_reg >= half_last);                     // see RL19

  // transfers start only with the unit and transmitter on, and no overrun halt
  wire halted   = overrun_reg && irq_en_reg[BIT_OVERRUN_IRQ];
  wire run_ok   = ctrl.unit_on && ctrl.tx_on && !halted;                 // see RL9 see RL7 see RL21
  wire tx_empty = !fifo_valid;
  wire busy     = (state_reg != ST_IDLE);

  wire [2:0] bit_idx   = 3'(bit_cnt_reg);
  wire       last_bit  = (bit_cnt_reg == 4'(FRAME_BITS - 1));            // see RL1
  wire [7:0] rx_pos    = 8'h01 << (ctrl.lsb_first_sel ? bit_idx : 3'd7 - bit_idx); // see RL11
  wire [2:0] tx_sel_i  = ctrl.lsb_first_sel ? bit_idx : 3'd7 - bit_idx;
  wire       start     = !busy && run_ok && fifo_valid && half_tick;
  wire       lead_edge = (state_reg == ST_LEAD) && half_tick;
  wire       trail_edge= (state_reg == ST_TRAIL) && half_tick;
  wire       frame_end = trail_edge && last_bit;
  wire       chain     = frame_end && fifo_valid && run_ok;
  wire [7:0] rx_byte   = rx_shift_reg | (sdi_sync_reg ? rx_pos : 8'h00);

  assign fifo_take = start || chain;                                     // see RL4

  // shifter state: lead edge drives data, trail edge samples
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (lead_edge) begin
          state_next = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (trail_edge) begin
          state_next = (last_bit && !chain) ? ST_IDLE : ST_LEAD;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // data-in pin passes two flip-flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
    end else begin
      sdi_meta_reg <= serial_data_in;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_reg <= 8'h00;
    end else if (half_tick || (!busy && !run_ok)) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // serial engine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      tx_shift_reg <= RST_HOLDING;
      rx_shift_reg <= RST_HOLDING;
      bit_cnt_reg  <= 4'h0;
      sclk_reg     <= 1'b0;
      sdo_reg      <= 1'b0;
      sel_reg      <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (start || chain) begin
        tx_shift_reg <= fifo_out;                                        // see RL5
        bit_cnt_reg  <= 4'h0;
        rx_shift_reg <= 8'h00;
        sel_reg      <= 1'b0;                                            // see RL22
      end else if (trail_edge) begin
        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
        rx_shift_reg <= rx_byte;                                         // see RL3
      end
      if (lead_edge) begin
        sdo_reg  <= tx_shift_reg[tx_sel_i];                              // see RL2 see RL3
        sclk_reg <= !ctrl.clock_polarity_sel;                            // see RL12
      end else if (trail_edge || !busy) begin
        sclk_reg <= ctrl.clock_polarity_sel;                             // see RL12 see RL21
      end
      if (frame_end && !chain) begin
        sel_reg <= 1'b1;                                                 // see RL22
      end
    end
  end

  // status flags: hardware sets win over software clears
  wire rx_done     = frame_end && ctrl.rx_on;                            // see RL8
  wire rx_store    = rx_done && (!rx_full_reg || rd_rx_hold);
  wire rx_overflow = rx_done && rx_full_reg && !rd_rx_hold;
  wire tx_end_set  = frame_end && !fifo_valid;                           // see RL23

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_hold_reg <= RST_HOLDING;
      rx_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
      tx_end_reg  <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_hold_reg <= rx_byte;                                          // see RL18
      end
      rx_full_reg <= rx_store || (rx_full_reg && !rd_rx_hold);
      overrun_reg <= rx_overflow || (overrun_reg && !rd_status);
      tx_end_reg  <= tx_end_set || (tx_end_reg && !rd_status);
    end
  end

  assign status.busy          = busy;
  assign status.tx_end_flag   = tx_end_reg;
  assign status.overrun_flag  = overrun_reg;
  assign status.tx_empty_flag = tx_empty;
  assign status.rx_full_flag  = rx_full_reg;

  // control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divider_reg   <= RST_CLOCK_DIVIDER;
      ctrl_bits_reg <= RST_CONTROL;
      irq_en_reg    <= RST_CONTROL;
    end else begin
      if (wr_divider) begin
        divider_reg <= reg_wdata & MASK_CLOCK_DIVIDER;
      end
      if (wr_control) begin
        ctrl_bits_reg <= reg_wdata & MASK_CONTROL_PRIMARY;               // see RL24
      end
      if (wr_irq_en) begin
        irq_en_reg <= reg_wdata & MASK_INTERRUPT_ENABLES;                // see RL24
      end
    end
  end

  // read mux; transmit holding reads back zero
  wire [7:0] rd_mux =
    (reg_addr == OFS_CLOCK_DIVIDER)     ? divider_reg :
    (reg_addr == OFS_SERIAL_STATUS)     ? {3'b000, status} :
    (reg_addr == OFS_RECEIVE_HOLDING)   ? rx_hold_reg :
    (reg_addr == OFS_CONTROL_PRIMARY)   ? ctrl_bits_reg :
    (reg_addr == OFS_INTERRUPT_ENABLES) ? irq_en_reg : 8'h00;

  wire irq_next = (tx_end_reg  && irq_en_reg[BIT_TX_END_IRQ])            // see RL13
               || (overrun_reg && irq_en_reg[BIT_OVERRUN_IRQ])           // see RL14
               || (tx_empty    && irq_en_reg[BIT_TX_EMPTY_IRQ])          // see RL15
               || (rx_full_reg && irq_en_reg[BIT_RX_FULL_IRQ]);          // see RL16

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : rdata_reg;
      irq_reg   <= irq_next && ctrl.unit_on;
    end
  end

  assign reg_rdata         = rdata_reg;
  assign irq               = irq_reg;
  assign serial_data_out   = sdo_reg;                                    // see RL6
  assign serial_clock_out  = sclk_reg;
  assign slave_select_out  = sel_reg;
  assign slave_select_oe_n = !ctrl.select_on;                            // see RL10

endmodule

// ===== sim/spi_master_sva.sv
`timescale 1ns/1ps
module spi_master_sva
  import spi_master_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       serial_data_out,
  input wire logic       serial_data_in,
  input wire logic       serial_clock_out,
  input wire logic       slave_select_out,
  input wire logic       slave_select_oe_n,
  input wire logic       tx_fifo_ready
);
  logic [7:0] ctl_reg, ien_reg, div_reg, gap_reg, edge_reg;
  wire        pol;
  wire        sck_chg;
  assign pol = ctl_reg[BIT_CLOCK_POLARITY];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow of the writable registers, taken from the bus itself
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_reg <= RST_CONTROL;
      ien_reg <= RST_CONTROL;
      div_reg <= RST_CLOCK_DIVIDER;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CONTROL_PRIMARY) ctl_reg <= reg_wdata & MASK_CONTROL_PRIMARY;
      if (reg_addr == OFS_INTERRUPT_ENABLES) ien_reg <= reg_wdata & MASK_INTERRUPT_ENABLES;
      if (reg_addr == OFS_CLOCK_DIVIDER) div_reg <= reg_wdata & MASK_CLOCK_DIVIDER;
    end
  end
  // cycles since the last clock edge or frame start, and clock edges per select period
  always_ff @(posedge clk_sys) begin
    if (rst || $changed(serial_clock_out) || $fell(slave_select_out)) gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
    if (rst || $fell(slave_select_out)) edge_reg <= 8'h00;
    else if ($changed(serial_clock_out)) edge_reg <= edge_reg + 8'h01;
  end
  a_select_enable: assert property (slave_select_oe_n == !ctl_reg[BIT_SELECT_ON])
    else $error("select enable wrong");
  a_data_lead: assert property ($changed(serial_data_out) |->
    $changed(serial_clock_out) && serial_clock_out != pol) else $error("data moved off leading edge");
  a_half_period: assert property ($changed(serial_clock_out) && !slave_select_out |->
    gap_reg == (div_reg >> 1) - 8'h01) else $error("clock half period wrong");
  a_frame_bits: assert property ($rose(slave_select_out) |-> edge_reg != 8'h00 &&
    ((edge_reg + 8'($changed(serial_clock_out))) & 8'h0F) == 8'h00) else $error("frame edge count wrong");
  a_select_release: assert property ($rose(slave_select_out) |-> serial_clock_out == pol)
    else $error("select rose with clock active");
  a_start_gate: assert property ($fell(slave_select_out) |->
    ctl_reg[BIT_TX_ON] && ctl_reg[BIT_UNIT_ON]) else $error("frame started while disabled");
  a_clock_parked: assert property (!ctl_reg[BIT_TX_ON] && $stable(ctl_reg) |->
    serial_clock_out == pol) else $error("clock not idle");
  a_irq_gate: assert property (irq |-> $past(ctl_reg[BIT_UNIT_ON]) && $past(ien_reg) != 8'h00)
    else $error("irq without enable");
  a_control_read: assert property ($past(reg_rd) && $past(reg_addr) == OFS_CONTROL_PRIMARY |->
    reg_rdata == ctl_reg) else $error("control readback wrong");
  a_holding_wo: assert property ($past(reg_rd) && $past(reg_addr) == OFS_TRANSMIT_HOLDING |->
    reg_rdata == 8'h00) else $error("transmit holding readable");
  c_frame_end: cover property ($rose(slave_select_out));
  c_back_to_back: cover property ($rose(slave_select_out) && edge_reg > 8'h10);
  c_irq: cover property ($rose(irq));
endmodule

// ===== sim/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
  input  wire logic serial_clock_out,
  input  wire logic serial_data_out,
  input  wire logic pol,
  output logic      serial_data_in
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic       act;
  int         nbit;
  initial begin
    serial_data_in = 1'b0;
    act = 1'b0;
    nbit = 0;
  end
  // select is ignored, as for a slave with its select grounded
  always @(serial_clock_out) begin
    if (serial_clock_out !== pol) begin
      if (nbit == 0) tx_sh = (send_q.size() > 0) ? send_q.pop_front() : 8'h00;
      serial_data_in = tx_sh[7];
      tx_sh = {tx_sh[6:0], 1'b0};
      act = 1'b1;
    end else if (act) begin
      rx_sh = {rx_sh[6:0], serial_data_out};
      act = 1'b0;
      nbit = nbit + 1;
      if (nbit == 8) begin
        got_q.push_back(rx_sh);
        nbit = 0;
        // line released between frames shows a changed level
        serial_data_in = ~serial_data_in;
      end
    end
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import spi_master_pkg::*;
;
  logic       clk_sys;
  logic       rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       irq;
  logic       serial_data_out;
  logic       serial_data_in;
  logic       serial_clock_out;
  logic       slave_select_out;
  logic       slave_select_oe_n;
  logic       tx_fifo_ready;
  logic       pol_m;
  logic [7:0] d;
  logic [7:0] b;
  logic [7:0] exp_tx[$];
  logic [7:0] exp_rx[$];
  logic [7:0] ra[0:6] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'h00};
  logic [7:0] rv[0:6] = '{8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ma[0:2] = '{8'hD6, 8'hD7, 8'hD2};
  logic [7:0] mv[0:2] = '{8'h7E, 8'h0F, 8'hFC};
  integer     seed = 32'h70B23062;
  int         error_cnt;
  int         n_checks;
  int         k;
  int         m;
  int         i;
  spi_master_controller spi_master_controller_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .serial_data_out(serial_data_out),
    .serial_data_in(serial_data_in), .serial_clock_out(serial_clock_out), .slave_select_out(slave_select_out),
    .slave_select_oe_n(slave_select_oe_n), .tx_fifo_ready(tx_fifo_ready));
  spi_slave_model spi_slave_model_inst (.serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .pol(pol_m), .serial_data_in(serial_data_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] rev(input logic [7:0] v, input logic on);
    rev = on ? {<<{v}} : v;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    if (a == OFS_CONTROL_PRIMARY) pol_m = v[BIT_CLOCK_POLARITY];
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
  task automatic wait_done(input int n);
    int t;
    t = 0;
    while (t < 30000 && !(spi_slave_model_inst.got_q.size() >= n && slave_select_out === 1'b1)) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 30000) begin
      error_cnt++;
      end_sim();
    end
    // the interrupt output is registered one edge after the end flag
    @(negedge clk_sys);
  endtask
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pol_m = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    for (i = 0; i < 7; i++) begin
      rd(ra[i], d);
      check(d, rv[i]);
    end
    for (i = 0; i < 3; i++) begin
      wr(ma[i], 8'hFF);
      rd(ma[i], d);
      check(d, mv[i]);
    end
    wr(OFS_INTERRUPT_ENABLES, 8'h08);
    for (m = 0; m < 4; m++) begin
      k = $unsigned($random(seed)) % 3;
      wr(OFS_CLOCK_DIVIDER, 8'(8 + 4 * k));
      // transmitter held off while the buffer is loaded
      wr(OFS_CONTROL_PRIMARY, {5'b00111, m[1:0], 1'b0});
      k = 0;
      while (tx_fifo_ready === 1'b1 && k < (m == 3 ? 12 : 1)) begin
        b = $random(seed);
        d = $random(seed);
        exp_tx.push_back(rev(b, m[1]));
        if (k == 0) exp_rx.push_back(rev(d, m[1]));
        spi_slave_model_inst.send_q.push_back(d);
        wr(OFS_TRANSMIT_HOLDING, b);
        k++;
      end
      if (m == 3) check(8'(k), 8'(FIFO_DEPTH));
      check({7'h00, slave_select_out}, 8'h01);
      wr(OFS_CONTROL_PRIMARY, {5'b01111, m[1:0], 1'b0});
      wait_done(k);
      check({7'h00, irq}, 8'h01);
      rd(OFS_SERIAL_STATUS, d);
      check(d, k > 1 ? 8'h0F : 8'h0B);
      rd(OFS_RECEIVE_HOLDING, d);
      check(d, exp_rx.pop_front());
      check({7'h00, irq}, 8'h00);
      while (spi_slave_model_inst.got_q.size() > 0) check(spi_slave_model_inst.got_q.pop_front(), exp_tx.pop_front());
      check({7'h00, serial_clock_out}, {7'h00, m[0]});
      rd(OFS_SERIAL_STATUS, d);
      check(d, 8'h02);
    end
    end_sim();
  end
endmodule
bind spi_master_controller spi_master_sva spi_master_sva_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .serial_data_out(serial_data_out),
  .serial_data_in(serial_data_in), .serial_clock_out(serial_clock_out), .slave_select_out(slave_select_out),
  .slave_select_oe_n(slave_select_oe_n), .tx_fifo_ready(tx_fifo_ready));
